/* File: rtl/psl_link.sv */
`timescale 1ns/10ps

module psl_fifo #(
  parameter int W = 21,
  parameter int DEPTH = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } psl_fifo_state_s;

  psl_fifo_state_s st;
  psl_fifo_state_s next_st;
  logic push;
  logic pop;

  assign o_in_ready = (st.cnt != CW'(DEPTH));
  assign o_out_valid = (st.cnt != '0);
  assign o_out_data = st.mem[st.rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = i_in_data;
      next_st.wp = AW'(st.wp + 1'b1);
    end
    next_st.rp = pop ? AW'(st.rp + 1'b1) : st.rp;
    next_st.cnt = CW'(st.cnt + CW'(push) - CW'(pop));
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////

module psl_link #(
  parameter int LOCK_CYC = psl_pkg::LOCK_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_shift_clock_in,
  input wire psl_pkg::psl_pixel_s i_parallel_pixel_in,
  input wire logic i_tx_sleep_select_n,
  output logic o_pixel_ready,
  output logic [2:0] o_serial_data_out_pair_p,
  output logic [2:0] o_serial_data_out_pair_n,
  output logic o_forwarded_clock_out_pair_p,
  output logic o_forwarded_clock_out_pair_n,
  output logic o_tx_oe,
  input wire logic [2:0] i_serial_data_in_pair_p,
  input wire logic [2:0] i_serial_data_in_pair_n,
  input wire logic i_forwarded_clock_in_pair_p,
  input wire logic i_forwarded_clock_in_pair_n,
  input wire logic i_rx_sleep_select_n,
  output psl_pkg::psl_pixel_s o_parallel_pixel_out,
  output logic o_shift_clock_out,
  output logic o_rx_oe
);
  typedef struct packed {
    logic [2:0] tck;
    logic tlvl;
    logic [2:0] twk;
    logic tawake;
    psl_pkg::psl_pixel_s [2:0] tdat;
    logic [31:0] tlock_cnt;
    logic tlocked;
    logic tready;
    logic [2:0] tslot;
    logic [1:0] tbit;
    psl_pkg::psl_pixel_s tsh;
    logic [2:0] tser;
    logic [2:0] tser_n;
    logic tfwd;
    logic tfwd_n;
    logic toe;
    logic [2:0] rck;
    logic rlvl;
    logic [2:0] rwk;
    logic rawake;
    logic [2:0][2:0] rdat;
    logic [4:0] rcnt;
    logic [31:0] rlock_cnt;
    logic rlocked;
    psl_pkg::psl_lanes_t rsh;
    psl_pkg::psl_pixel_s rpix;
    logic rsclk;
    logic roe;
  } psl_link_state_s;

  psl_link_state_s st;
  psl_link_state_s next_st;
  logic tx_fall;
  logic tx_push;
  logic tx_pop;
  logic tx_frame;
  logic fifo_in_ready;
  logic fifo_out_valid;
  psl_pkg::psl_pixel_s fifo_out_data;
  logic rx_rise;
  logic rx_load;

  function automatic logic [2:0] lane_pick(psl_pkg::psl_pixel_s w, logic [2:0] slot);
    psl_pkg::psl_lanes_t l;
    logic [2:0] r;
    l = psl_pkg::psl_lanes_t'(w);
    for (int k = 0; k < psl_pkg::NUM_PAIRS; k++) begin
      r[k] = l[k][slot];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // transmit side
  assign tx_fall = st.tlvl && !st.tck[1] && !st.tck[2];
  assign tx_push = tx_fall && st.tlocked;
  assign tx_frame = (st.tbit == psl_pkg::BIT_LAST) && (st.tslot == psl_pkg::SLOT_LAST);
  assign tx_pop = tx_frame && st.tawake && st.tlocked;

  psl_fifo #(
    .W(psl_pkg::PIX_W),
    .DEPTH(psl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_arst_n(i_arst_n),
    .i_in_valid(tx_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(st.tdat[2]),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(tx_pop),
    .o_out_data(fifo_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // receive side, and the next-state logic of both sides
  assign rx_rise = !st.rlvl && st.rck[1] && st.rck[2];
  assign rx_load = st.rawake && (st.rcnt == psl_pkg::RX_LOAD_AT);
  always_comb begin
    next_st = st;
    // transmit: pin synchronisers
    next_st.tck = {st.tck[1:0], i_shift_clock_in};
    next_st.twk = {st.twk[1:0], i_tx_sleep_select_n};
    next_st.tdat = {st.tdat[1:0], i_parallel_pixel_in};
    next_st.tlvl = (st.tck[1] == st.tck[2]) ? st.tck[2] : st.tlvl;
    next_st.tawake = (st.twk[1] == st.twk[2]) ? st.twk[2] : st.tawake;
    next_st.tready = fifo_in_ready && st.tlocked;
    // transmit lock
    if (!st.tawake) begin
      next_st.tlock_cnt = '0;
      next_st.tlocked = 1'b0;
    end else if (st.tlock_cnt < 32'(LOCK_CYC)) begin
      next_st.tlock_cnt = st.tlock_cnt + 32'h1;
    end else begin
      next_st.tlocked = 1'b1;
    end
    // transmit serializer
    if (!st.tawake) begin
      next_st.tslot = psl_pkg::SLOT_LAST;
      next_st.tbit = psl_pkg::BIT_LAST;
      next_st.tser = '0;
      next_st.tser_n = '0;
      next_st.tfwd = 1'b0;
      next_st.tfwd_n = 1'b0;
      next_st.toe = 1'b0;
    end else begin
      next_st.toe = 1'b1;
      next_st.tbit = 2'(st.tbit + 2'h1);
      if (st.tbit == psl_pkg::BIT_LAST) begin
        next_st.tslot = tx_frame ? 3'h0 : 3'(st.tslot + 3'h1);
      end
      next_st.tsh = tx_frame ? ((st.tlocked && fifo_out_valid) ? fifo_out_data : '0) : st.tsh;
      next_st.tser = lane_pick(next_st.tsh, next_st.tslot);
      next_st.tser_n = ~next_st.tser;
      next_st.tfwd = (next_st.tslot < psl_pkg::FWD_HIGH_SLOTS);
      next_st.tfwd_n = !next_st.tfwd;
    end
    // receive: pin synchronisers
    next_st.rck = {st.rck[1:0], i_forwarded_clock_in_pair_p && !i_forwarded_clock_in_pair_n};
    next_st.rwk = {st.rwk[1:0], i_rx_sleep_select_n};
    next_st.rdat = {st.rdat[1:0], i_serial_data_in_pair_p & ~i_serial_data_in_pair_n};
    next_st.rlvl = (st.rck[1] == st.rck[2]) ? st.rck[2] : st.rlvl;
    next_st.rawake = (st.rwk[1] == st.rwk[2]) ? st.rwk[2] : st.rawake;
    if (!st.rawake) begin
      next_st.rlock_cnt = '0;
      next_st.rlocked = 1'b0;
    end else if (st.rlock_cnt < 32'(LOCK_CYC)) begin
      next_st.rlock_cnt = st.rlock_cnt + 32'h1;
    end else begin
      next_st.rlocked = 1'b1;
    end
    // receive: bit slots counted from each forwarded clock rise
    if (rx_rise) begin
      next_st.rcnt = '0;
    end else if (st.rcnt != psl_pkg::RX_CNT_MAX) begin
      next_st.rcnt = 5'(st.rcnt + 5'h1);
    end
    if ((st.rcnt[1:0] == psl_pkg::RX_SAMPLE_PHASE) && (st.rcnt[4:2] <= psl_pkg::SLOT_LAST)) begin
      for (int k = 0; k < psl_pkg::NUM_PAIRS; k++) begin
        next_st.rsh[k][st.rcnt[4:2]] = st.rdat[2][k];
      end
    end
    if (!st.rawake || !st.rlocked) begin
      next_st.rpix = '0;
      next_st.rsclk = 1'b0;
    end else if (rx_load) begin
      next_st.rpix = psl_pkg::psl_pixel_s'(st.rsh);
      next_st.rsclk = 1'b1;
    end else if (st.rcnt == psl_pkg::RX_FALL_AT) begin
      next_st.rsclk = 1'b0;
    end
    next_st.roe = st.rawake;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st <= '0;
      st.tslot <= psl_pkg::SLOT_LAST;
      st.tbit <= psl_pkg::BIT_LAST;
      st.rcnt <= psl_pkg::RX_CNT_MAX;
    end else begin
      st <= next_st;
    end
  end

  assign o_pixel_ready = st.tready;
  assign o_serial_data_out_pair_p = st.tser;
  assign o_serial_data_out_pair_n = st.tser_n;
  assign o_forwarded_clock_out_pair_p = st.tfwd;
  assign o_forwarded_clock_out_pair_n = st.tfwd_n;
  assign o_tx_oe = st.toe;
  assign o_parallel_pixel_out = st.rpix;
  assign o_shift_clock_out = st.rsclk;
  assign o_rx_oe = st.roe;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  a_tx_sleep_hiz: assert property (!st.tawake |=> !o_tx_oe && !o_forwarded_clock_out_pair_p)
    else $error("transmit outputs enabled while asleep");
  a_rx_sleep_hiz: assert property (!st.rawake |=> !o_rx_oe && o_parallel_pixel_out == '0)
    else $error("receive outputs enabled while asleep");
  a_tx_push_edge: assert property (tx_push |-> st.tlvl ##1 !st.tlvl)
    else $error("capture not on a falling input clock edge");
  a_tx_lock_gate: assert property (!st.tlocked |-> !tx_push && !tx_pop)
    else $error("transmit data moved before lock");
  a_rx_lock_hold: assert property (!st.rlocked |=> !o_shift_clock_out && o_parallel_pixel_out == '0)
    else $error("receive outputs valid before lock");
  a_fwd_period: assert property (disable iff (!i_arst_n || !st.tawake)
      $rose(st.tfwd) |-> ##16 $fell(st.tfwd) ##12 $rose(st.tfwd))
    else $error("forwarded clock period is not seven slots");
  a_slot_map: assert property (st.toe && st.tbit == 2'h1 |-> st.tser == lane_pick(st.tsh, st.tslot))
    else $error("serial lane does not match word slot");
  a_rx_word_load: assert property (rx_load && st.rlocked |=> o_parallel_pixel_out == $past(st.rsh) && o_shift_clock_out)
    else $error("received word not presented");
  a_rx_strobe: assert property ($fell(st.rsclk) && st.rlocked |-> $stable(st.rpix))
    else $error("output changed at strobe edge");

  c_tx_push: cover property (tx_push);
  c_fifo_full: cover property (!fifo_in_ready);
  c_rx_word: cover property (rx_load && st.rlocked ##[1:40] $fell(st.rsclk));
endmodule

/* File: rtl/psl_pkg.sv */
package psl_pkg;

  // colour fields hold their lsb at the lowest bit: red[0] is word bit 0
  typedef struct packed {
    logic pixel_valid;
    logic frame_sync;
    logic line_sync;
    logic [5:0] blue;
    logic [5:0] green;
    logic [5:0] red;
  } psl_pixel_s;

  typedef logic [2:0][6:0] psl_lanes_t;

  localparam int PIX_W = 21;
  localparam int NUM_PAIRS = 3;
  localparam int SLOTS = 7;
  localparam int CLK_HZ = 40_000_000;
  localparam int LOCK_TIME_MS = 10;
  localparam int LOCK_CYC = (LOCK_TIME_MS * (CLK_HZ / 1000));
  localparam int FIFO_DEPTH = 16;
  localparam logic [1:0] BIT_LAST = 2'h3;
  localparam logic [2:0] SLOT_LAST = 3'h6;
  localparam logic [2:0] FWD_HIGH_SLOTS = 3'h4;
  localparam logic [1:0] RX_SAMPLE_PHASE = 2'h1;
  localparam logic [4:0] RX_LOAD_AT = 5'h1a;
  localparam logic [4:0] RX_FALL_AT = 5'h0c;
  localparam logic [4:0] RX_CNT_MAX = 5'h1f;

endpackage

/* File: tb/psl_cable.sv */
`timescale 1ns/10ps

module psl_cable (
  input wire logic i_clk_sys,
  input wire logic i_oe,
  input wire logic [3:0] i_p,
  input wire logic [3:0] i_n,
  output logic [3:0] o_p,
  output logic [3:0] o_n
);
  logic tog = 1'b0;

  always @(posedge i_clk_sys) begin
    tog <= ~tog;
  end

  // released pairs wander with p equal to n, so no level is ever seen
  assign o_p = i_oe ? i_p : {4{tog}};
  assign o_n = i_oe ? i_n : {4{tog}};
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/10ps

module testbench;
  logic clk, rst_n, sck, txs, rxs, rdy, fcp, fcn, txoe, rxoe, sco, pf, ps, full;
  logic [2:0] dp, dn;
  logic [3:0] lp, ln;
  psl_pkg::psl_pixel_s pix, pout;
  logic [20:0] sq[$];
  logic [20:0] wq[$];
  logic [20:0] ww;
  int errors, num_checks, seed, cnt;

  psl_link #(.LOCK_CYC(50)) dut_u (.i_clk_sys(clk), .i_arst_n(rst_n), .i_shift_clock_in(sck),
    .i_parallel_pixel_in(pix), .i_tx_sleep_select_n(txs), .o_pixel_ready(rdy),
    .o_serial_data_out_pair_p(dp), .o_serial_data_out_pair_n(dn),
    .o_forwarded_clock_out_pair_p(fcp), .o_forwarded_clock_out_pair_n(fcn), .o_tx_oe(txoe),
    .i_serial_data_in_pair_p(lp[2:0]), .i_serial_data_in_pair_n(ln[2:0]),
    .i_forwarded_clock_in_pair_p(lp[3]), .i_forwarded_clock_in_pair_n(ln[3]),
    .i_rx_sleep_select_n(rxs), .o_parallel_pixel_out(pout), .o_shift_clock_out(sco),
    .o_rx_oe(rxoe));

  psl_cable cab_u (.i_clk_sys(clk), .i_oe(txoe), .i_p({fcp, dp}), .i_n({fcn, dn}), .o_p(lp),
    .o_n(ln));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task cmp_word(input logic [20:0] got, input logic [20:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task cmp_bit(input logic got, input logic exp);
    cmp_word({20'h0, got}, {20'h0, exp});
  endtask

  task summarize;
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // junk word around the rising edge, real word around the falling edge
  task send(input logic [20:0] w);
    pix = ~w;
    sck = 1'b1;
    cyc(2);
    pix = w;
    cyc(2);
    sck = 1'b0;
    sq.push_back(w);
    cyc(4);
  endtask

  task wait_ready;
    for (int i = 0; i < 200 && rdy !== 1'b1; i++) cyc(1);
    cmp_bit(rdy, 1'b1);
  endtask

  // wire word must be a later sent word, dropped ones skipped
  task match(input logic [20:0] w);
    while (sq.size() > 0 && sq[0] !== w) sq.delete(0);
    cmp_word(sq.size() > 0 ? sq[0] : ~w, w);
    if (sq.size() > 0) sq.delete(0);
  endtask

  function logic [20:0] rnd;
    rnd = 21'($random(seed));
    if (rnd == 21'h0) rnd = 21'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk) begin
    if (txoe === 1'b1) cmp_word({17'h0, fcn, dn}, {17'h0, ~fcp, ~dp});
    cnt = (fcp === 1'b1 && pf === 1'b0) ? 0 : cnt + 1;
    pf = fcp;
    if (cnt % 4 == 2 && cnt < 28) begin
      for (int k = 0; k < 3; k++) ww[7 * k + cnt / 4] = dp[k];
    end
    if (cnt == 27) begin
      if (ww !== 21'h0) begin
        wq.push_back(ww);
        match(ww);
      end
      ww = 21'h0;
    end
    if (ps === 1'b1 && sco === 1'b0 && pout !== 21'h0) begin
      cmp_word(pout, wq.size() > 0 ? wq.pop_front() : ~pout);
    end
    ps = sco;
  end

  initial begin
    #2000000;
    errors++;
    summarize;
  end

  initial begin
    seed = 32'h672f822e;
    rst_n = 1'b0;
    sck = 1'b1;
    pix = '0;
    txs = 1'b1;
    rxs = 1'b1;
    errors = 0;
    num_checks = 0;
    cnt = 100;
    pf = 1'b0;
    ps = 1'b0;
    ww = 21'h0;
    full = 1'b0;
    cyc(10);
    rst_n = 1'b1;
    wait_ready;
    cmp_bit(txoe, 1'b1);
    cmp_bit(rxoe, 1'b1);
    send(21'h000001);
    send(21'h1fffff);
    send(21'h155555);
    send(21'h0aaaaa);
    repeat (12) send(rnd());
    cyc(600);
    repeat (40) begin
      send(rnd());
      if (rdy !== 1'b1) full = 1'b1;
    end
    cmp_bit(full, 1'b1);
    cyc(700);
    txs = 1'b0;
    rxs = 1'b0;
    cyc(8);
    cmp_word({10'h0, dp, dn, fcp, fcn, txoe, rxoe, sco}, 21'h0);
    cmp_word(pout, 21'h0);
    txs = 1'b1;
    rxs = 1'b1;
    cyc(10);
    cmp_bit(rdy, 1'b0);
    wait_ready;
    repeat (10) send(rnd());
    cyc(600);
    cmp_word(21'(wq.size()), 21'h0);
    cmp_word(21'(sq.size()), 21'h0);
    summarize;
  end
endmodule
